/* File: pec_defs.vh */
// constants shared by the performance event counter block
`ifndef PEC_DEFS_VH
`define PEC_DEFS_VH

`define PEC_ADDR_W          8
`define PEC_DATA_W          32

`define PEC_ADDR_CTRL0      8'h00
`define PEC_ADDR_CNT0_LO    8'h04
`define PEC_ADDR_CNT0_HI    8'h08
`define PEC_ADDR_CTRL1      8'h0C
`define PEC_ADDR_CNT1_LO    8'h10
`define PEC_ADDR_CNT1_HI    8'h14
`define PEC_ADDR_IRQ_STAT   8'h18
`define PEC_ADDR_IRQ_EN     8'h1C
`define PEC_ADDR_IRQ_CLR    8'h20

`define PEC_CTRL0_RST       32'hC0000000
`define PEC_CTRL1_RST       32'h40000000
`define PEC_CTRL_FIXED_MASK 32'hC0000000

`define PEC_CTRL_EVT_MSB    8
`define PEC_CTRL_EVT_LSB    5
`define PEC_CTRL_IE         4
`define PEC_Q_U             3
`define PEC_Q_S             2
`define PEC_Q_K             1
`define PEC_Q_EXL           0
`define PEC_QUAL_RST        4'h0
`define PEC_EVT_RST         4'h0

`define PEC_MODE_KERNEL     2'h0
`define PEC_MODE_SUPER      2'h1
`define PEC_MODE_USER       2'h2

`define PEC_EXC_TLB_REFILL_A 6'h22
`define PEC_EXC_TLB_REFILL_B 6'h23
`define PEC_EXC_CODE_ZERO    6'h00
`define PEC_EXC_INTERNAL     6'h3F

`define PEC_EV0_CYCLES      0
`define PEC_EV0_BRANCH      1
`define PEC_EV0_JREG        2
`define PEC_EV0_RET_JUMP    3
`define PEC_EV0_IC_MISS     4
`define PEC_EV0_INT_A       5
`define PEC_EV0_MEM         6
`define PEC_EV0_FP_A        7
`define PEC_EV0_BHT         8
`define PEC_EV0_MREAD       9
`define PEC_EV0_FIXQ_FULL   10
`define PEC_EV0_ROQ_FULL    11
`define PEC_EV0_SYSQ_FULL   12
`define PEC_EV0_TLB_REFILL  13
`define PEC_EV0_EXC_ZERO    14
`define PEC_EV0_EXC_INT     15

`define PEC_EV1_COMMIT      0
`define PEC_EV1_BR_MISS     1
`define PEC_EV1_JREG_MISS   2
`define PEC_EV1_RET_MISS    3
`define PEC_EV1_DC_MISS     4
`define PEC_EV1_INT_B       5
`define PEC_EV1_FP_B        6
`define PEC_EV1_UNCACHED    7
`define PEC_EV1_BHT_MISS    8
`define PEC_EV1_MWRITE      9
`define PEC_EV1_FPQ_FULL    10
`define PEC_EV1_BRQ_FULL    11
`define PEC_EV1_ITLB_MISS   12
`define PEC_EV1_ANY_EXC     13
`define PEC_EV1_SPEC_MISS   14
`define PEC_EV1_SYS_FWD     15

`define PEC_IRQ_W           2
`define PEC_IRQ_CNT0        0
`define PEC_IRQ_CNT1        1

`endif

/* File: pec_counter.v */
// one 64-bit event counter with privilege qualification
`timescale 1ns/1ps
`include "pec_defs.vh"

module pec_counter (
	input  wire        clk,
	input  wire        rst,
	input  wire [3:0]  qual_en,
	input  wire [1:0]  priv_mode,
	input  wire        exc_lvl,
	input  wire        err_lvl,
	input  wire [3:0]  evt_sel,
	input  wire [15:0] evt_vec,
	input  wire        wr_lo,
	input  wire        wr_hi,
	input  wire [31:0] wr_data,
	output reg  [63:0] count_q,
	output reg         ovf_q
);

	reg  [63:0] count_d;
	wire        priv_k;
	wire        priv_s;
	wire        priv_u;
	wire        priv_x;
	wire        priv_ok;
	wire        hit;
	wire        wr_any;

	assign priv_k  = qual_en[`PEC_Q_K] & (priv_mode == `PEC_MODE_KERNEL) & ~exc_lvl & ~err_lvl;
	assign priv_s  = qual_en[`PEC_Q_S] & (priv_mode == `PEC_MODE_SUPER) & ~exc_lvl & ~err_lvl;
	assign priv_u  = qual_en[`PEC_Q_U] & (priv_mode == `PEC_MODE_USER) & ~exc_lvl & ~err_lvl;
	assign priv_x  = qual_en[`PEC_Q_EXL] & exc_lvl & ~err_lvl;
	assign priv_ok = priv_k | priv_s | priv_u | priv_x;
	assign hit     = evt_vec[evt_sel] & priv_ok;
	assign wr_any  = wr_lo | wr_hi;

	// software write beats a same-cycle increment so a loaded value is exact
	always @* begin
		count_d = count_q;
		if (wr_lo) begin
			count_d = {count_q[63:32], wr_data};
		end else if (wr_hi) begin
			count_d = {wr_data, count_q[31:0]};
		end else if (hit) begin
			count_d = count_q + 64'h0000000000000001;
		end
	end

	always @(posedge clk) begin
		if (rst) begin
			count_q <= 64'h0000000000000000;
			ovf_q   <= 1'b0;
		end else begin
			count_q <= count_d;
			ovf_q   <= hit & ~wr_any & ~count_q[63] & count_d[63];
		end
	end

endmodule // pec_counter

/* File: pec_top.v */
// performance event selection, two counters, register port and overflow interrupt
`timescale 1ns/1ps
`include "pec_defs.vh"

module pec_top (
	input  wire        CLK,
	input  wire        SYS_RST,
	// register port
	input  wire [7:0]  ADDR,
	input  wire [31:0] WR_DATA,
	input  wire        WR_EN,
	input  wire        RD_EN,
	output reg  [31:0] RD_DATA,
	// interrupt and cause flag
	output reg         IRQ,
	output reg         CAUSE_PERF_PENDING,
	// privilege state
	input  wire [1:0]  PRIVILEGE_MODE_FIELD,
	input  wire        EXCEPTION_LEVEL_FLAG,
	input  wire        ERROR_LEVEL_FLAG,
	// counter 0 sources
	input  wire        BRANCH_VALID,
	input  wire        JUMP_REG_STROBE,
	input  wire        RETURN_JUMP_STROBE,
	input  wire        IMEM_RD_VALID,
	input  wire        IMEM_RD_ALLOW,
	input  wire        INT_UNIT_A_ISSUE,
	input  wire        MEM_UNIT_ISSUE,
	input  wire        FP_UNIT_A_ISSUE,
	input  wire        BHT_PREDICT,
	input  wire        MREAD_VALID,
	input  wire        MREAD_ALLOW,
	input  wire        FIX_QUEUE_FULL,
	input  wire        REORDER_QUEUE_FULL,
	input  wire        SYSCTL_QUEUE_FULL,
	input  wire        EXCEPTION_STROBE,
	input  wire [5:0]  EXCEPTION_CODE,
	// counter 1 sources
	input  wire        COMMIT_VALID,
	input  wire        BRANCH_MISPREDICT,
	input  wire        JUMP_REG_MISPREDICT,
	input  wire        RETURN_JUMP_MISPREDICT,
	input  wire        DMEM_RD_VALID,
	input  wire        DMEM_RD_ALLOW,
	input  wire        INT_UNIT_B_ISSUE,
	input  wire        FP_UNIT_B_ISSUE,
	input  wire        UNCACHED_VALID,
	input  wire        UNCACHED_ALLOW,
	input  wire        BHT_MISPREDICT,
	input  wire        MWRITE_VALID,
	input  wire        MWRITE_ALLOW,
	input  wire        FP_QUEUE_FULL,
	input  wire        BRANCH_QUEUE_FULL,
	input  wire        ITLB_PROBE_OP,
	input  wire        LOAD_SPEC_MISS,
	input  wire        SYSCTL_LOAD_FORWARD
);

	// control register fields
	reg  [3:0]  qual0_q;
	reg  [3:0]  qual0_d;
	reg  [3:0]  qual1_q;
	reg  [3:0]  qual1_d;
	reg  [3:0]  evt0_q;
	reg  [3:0]  evt0_d;
	reg  [3:0]  evt1_q;
	reg  [3:0]  evt1_d;
	reg         ie0_q;
	reg         ie0_d;
	reg         ie1_q;
	reg         ie1_d;

	// interrupt registers
	reg  [1:0]  irq_stat_q;
	reg  [1:0]  irq_stat_d;
	reg  [1:0]  irq_en_q;
	reg  [1:0]  irq_en_d;
	reg         irq_d;
	reg         pend_d;

	// read path
	reg  [31:0] rd_data_d;

	// decoded strobes
	wire        wr_ctrl0;
	wire        wr_ctrl1;
	wire        wr_cnt0_lo;
	wire        wr_cnt0_hi;
	wire        wr_cnt1_lo;
	wire        wr_cnt1_hi;
	wire        wr_irq_en;
	wire        wr_irq_clr;

	wire [15:0] evt0_vec;
	wire [15:0] evt1_vec;
	wire [63:0] cnt0;
	wire [63:0] cnt1;
	wire        ovf0;
	wire        ovf1;
	wire [1:0]  irq_set;
	wire [31:0] ctrl0_rd;
	wire [31:0] ctrl1_rd;

	assign wr_ctrl0   = WR_EN & (ADDR == `PEC_ADDR_CTRL0);
	assign wr_ctrl1   = WR_EN & (ADDR == `PEC_ADDR_CTRL1);
	assign wr_cnt0_lo = WR_EN & (ADDR == `PEC_ADDR_CNT0_LO);
	assign wr_cnt0_hi = WR_EN & (ADDR == `PEC_ADDR_CNT0_HI);
	assign wr_cnt1_lo = WR_EN & (ADDR == `PEC_ADDR_CNT1_LO);
	assign wr_cnt1_hi = WR_EN & (ADDR == `PEC_ADDR_CNT1_HI);
	assign wr_irq_en  = WR_EN & (ADDR == `PEC_ADDR_IRQ_EN);
	assign wr_irq_clr = WR_EN & (ADDR == `PEC_ADDR_IRQ_CLR);

	// counter 0 event table, bit index equals event code
	assign evt0_vec[`PEC_EV0_CYCLES]     = 1'b1;
	assign evt0_vec[`PEC_EV0_BRANCH]     = BRANCH_VALID;
	assign evt0_vec[`PEC_EV0_JREG]       = JUMP_REG_STROBE;
	assign evt0_vec[`PEC_EV0_RET_JUMP]   = RETURN_JUMP_STROBE;
	assign evt0_vec[`PEC_EV0_IC_MISS]    = IMEM_RD_VALID & IMEM_RD_ALLOW;
	assign evt0_vec[`PEC_EV0_INT_A]      = INT_UNIT_A_ISSUE;
	assign evt0_vec[`PEC_EV0_MEM]        = MEM_UNIT_ISSUE;
	assign evt0_vec[`PEC_EV0_FP_A]       = FP_UNIT_A_ISSUE;
	assign evt0_vec[`PEC_EV0_BHT]        = BHT_PREDICT;
	assign evt0_vec[`PEC_EV0_MREAD]      = MREAD_VALID & MREAD_ALLOW;
	assign evt0_vec[`PEC_EV0_FIXQ_FULL]  = FIX_QUEUE_FULL;
	assign evt0_vec[`PEC_EV0_ROQ_FULL]   = REORDER_QUEUE_FULL;
	assign evt0_vec[`PEC_EV0_SYSQ_FULL]  = SYSCTL_QUEUE_FULL;
	assign evt0_vec[`PEC_EV0_TLB_REFILL] = EXCEPTION_STROBE &
		((EXCEPTION_CODE == `PEC_EXC_TLB_REFILL_A) | (EXCEPTION_CODE == `PEC_EXC_TLB_REFILL_B));
	assign evt0_vec[`PEC_EV0_EXC_ZERO]   = EXCEPTION_STROBE & (EXCEPTION_CODE == `PEC_EXC_CODE_ZERO);
	assign evt0_vec[`PEC_EV0_EXC_INT]    = EXCEPTION_STROBE & (EXCEPTION_CODE == `PEC_EXC_INTERNAL);

	// counter 1 event table
	assign evt1_vec[`PEC_EV1_COMMIT]     = COMMIT_VALID;
	assign evt1_vec[`PEC_EV1_BR_MISS]    = BRANCH_MISPREDICT;
	assign evt1_vec[`PEC_EV1_JREG_MISS]  = JUMP_REG_MISPREDICT;
	assign evt1_vec[`PEC_EV1_RET_MISS]   = RETURN_JUMP_MISPREDICT;
	assign evt1_vec[`PEC_EV1_DC_MISS]    = DMEM_RD_VALID & DMEM_RD_ALLOW;
	assign evt1_vec[`PEC_EV1_INT_B]      = INT_UNIT_B_ISSUE;
	assign evt1_vec[`PEC_EV1_FP_B]       = FP_UNIT_B_ISSUE;
	assign evt1_vec[`PEC_EV1_UNCACHED]   = UNCACHED_VALID & UNCACHED_ALLOW;
	assign evt1_vec[`PEC_EV1_BHT_MISS]   = BHT_MISPREDICT;
	assign evt1_vec[`PEC_EV1_MWRITE]     = MWRITE_VALID & MWRITE_ALLOW;
	assign evt1_vec[`PEC_EV1_FPQ_FULL]   = FP_QUEUE_FULL;
	assign evt1_vec[`PEC_EV1_BRQ_FULL]   = BRANCH_QUEUE_FULL;
	assign evt1_vec[`PEC_EV1_ITLB_MISS]  = EXCEPTION_STROBE & ITLB_PROBE_OP;
	assign evt1_vec[`PEC_EV1_ANY_EXC]    = EXCEPTION_STROBE;
	assign evt1_vec[`PEC_EV1_SPEC_MISS]  = LOAD_SPEC_MISS;
	assign evt1_vec[`PEC_EV1_SYS_FWD]    = SYSCTL_LOAD_FORWARD;

	pec_counter u_cnt0 (
		.clk       (CLK),
		.rst       (SYS_RST),
		.qual_en   (qual0_q),
		.priv_mode (PRIVILEGE_MODE_FIELD),
		.exc_lvl   (EXCEPTION_LEVEL_FLAG),
		.err_lvl   (ERROR_LEVEL_FLAG),
		.evt_sel   (evt0_q),
		.evt_vec   (evt0_vec),
		.wr_lo     (wr_cnt0_lo),
		.wr_hi     (wr_cnt0_hi),
		.wr_data   (WR_DATA),
		.count_q   (cnt0),
		.ovf_q     (ovf0)
	);

	pec_counter u_cnt1 (
		.clk       (CLK),
		.rst       (SYS_RST),
		.qual_en   (qual1_q),
		.priv_mode (PRIVILEGE_MODE_FIELD),
		.exc_lvl   (EXCEPTION_LEVEL_FLAG),
		.err_lvl   (ERROR_LEVEL_FLAG),
		.evt_sel   (evt1_q),
		.evt_vec   (evt1_vec),
		.wr_lo     (wr_cnt1_lo),
		.wr_hi     (wr_cnt1_hi),
		.wr_data   (WR_DATA),
		.count_q   (cnt1),
		.ovf_q     (ovf1)
	);

	// fixed top bits come from the reset image so they read back unchanged
	assign ctrl0_rd = (`PEC_CTRL0_RST & `PEC_CTRL_FIXED_MASK) |
		{23'h000000, evt0_q, ie0_q, qual0_q};
	assign ctrl1_rd = (`PEC_CTRL1_RST & `PEC_CTRL_FIXED_MASK) |
		{23'h000000, evt1_q, ie1_q, qual1_q};

	// per-counter IE gates the overflow before it becomes sticky
	assign irq_set[`PEC_IRQ_CNT0] = ovf0 & ie0_q;
	assign irq_set[`PEC_IRQ_CNT1] = ovf1 & ie1_q;

	always @* begin
		qual0_d = qual0_q;
		evt0_d  = evt0_q;
		ie0_d   = ie0_q;
		qual1_d = qual1_q;
		evt1_d  = evt1_q;
		ie1_d   = ie1_q;
		if (wr_ctrl0) begin
			qual0_d = WR_DATA[`PEC_Q_U:`PEC_Q_EXL];
			evt0_d  = WR_DATA[`PEC_CTRL_EVT_MSB:`PEC_CTRL_EVT_LSB];
			ie0_d   = WR_DATA[`PEC_CTRL_IE];
		end
		if (wr_ctrl1) begin
			qual1_d = WR_DATA[`PEC_Q_U:`PEC_Q_EXL];
			evt1_d  = WR_DATA[`PEC_CTRL_EVT_MSB:`PEC_CTRL_EVT_LSB];
			ie1_d   = WR_DATA[`PEC_CTRL_IE];
		end
	end

	// a new overflow in the clear cycle survives: set beats clear
	always @* begin
		irq_en_d   = irq_en_q;
		irq_stat_d = irq_stat_q;
		if (wr_irq_en) begin
			irq_en_d = WR_DATA[`PEC_IRQ_W-1:0];
		end
		if (wr_irq_clr) begin
			irq_stat_d = irq_stat_q & ~WR_DATA[`PEC_IRQ_W-1:0];
		end
		irq_stat_d = irq_stat_d | irq_set;
		irq_d      = |(irq_stat_d & irq_en_d);
		pend_d     = |irq_stat_d;
	end

	// unmapped and write-only addresses read as zero
	always @* begin
		rd_data_d = 32'h00000000;
		if (RD_EN) begin
			case (ADDR)
				`PEC_ADDR_CTRL0:    rd_data_d = ctrl0_rd;
				`PEC_ADDR_CNT0_LO:  rd_data_d = cnt0[31:0];
				`PEC_ADDR_CNT0_HI:  rd_data_d = cnt0[63:32];
				`PEC_ADDR_CTRL1:    rd_data_d = ctrl1_rd;
				`PEC_ADDR_CNT1_LO:  rd_data_d = cnt1[31:0];
				`PEC_ADDR_CNT1_HI:  rd_data_d = cnt1[63:32];
				`PEC_ADDR_IRQ_STAT: rd_data_d = {30'h00000000, irq_stat_q};
				`PEC_ADDR_IRQ_EN:   rd_data_d = {30'h00000000, irq_en_q};
				default:            rd_data_d = 32'h00000000;
			endcase
		end
	end

	always @(posedge CLK) begin
		if (SYS_RST) begin
			qual0_q            <= `PEC_QUAL_RST;
			evt0_q             <= `PEC_EVT_RST;
			ie0_q              <= 1'b0;
			qual1_q            <= `PEC_QUAL_RST;
			evt1_q             <= `PEC_EVT_RST;
			ie1_q              <= 1'b0;
			irq_stat_q         <= 2'h0;
			irq_en_q           <= 2'h0;
			IRQ                <= 1'b0;
			CAUSE_PERF_PENDING <= 1'b0;
			RD_DATA            <= 32'h00000000;
		end else begin
			qual0_q            <= qual0_d;
			evt0_q             <= evt0_d;
			ie0_q              <= ie0_d;
			qual1_q            <= qual1_d;
			evt1_q             <= evt1_d;
			ie1_q              <= ie1_d;
			irq_stat_q         <= irq_stat_d;
			irq_en_q           <= irq_en_d;
			IRQ                <= irq_d;
			CAUSE_PERF_PENDING <= pend_d;
			RD_DATA            <= rd_data_d;
		end
	end

endmodule // pec_top

/* File: pec_top_chk.sv */
// checker for the register port and interrupt outputs of the event counter block
`timescale 1ns/1ps
module pec_top_chk (
	input wire        CLK,
	input wire        SYS_RST,
	input wire [7:0]  ADDR,
	input wire [31:0] WR_DATA,
	input wire        WR_EN,
	input wire        RD_EN,
	input wire [31:0] RD_DATA,
	input wire        IRQ,
	input wire        CAUSE_PERF_PENDING
);
	default clocking chk_cb @(posedge CLK);
	endclocking
	default disable iff (SYS_RST);

	chk_rd_idle: assert property (!RD_EN |=> RD_DATA == 32'h0)
		else $error("read data not zero outside a read answer");
	chk_ctrl0_fixed: assert property (RD_EN && ADDR == 8'h00 |=> RD_DATA[31:30] == 2'h3)
		else $error("control 0 fixed bits wrong");
	chk_ctrl1_fixed: assert property (RD_EN && ADDR == 8'h0C |=> RD_DATA[31:30] == 2'h1)
		else $error("control 1 fixed bits wrong");
	chk_ctrl_gap: assert property (RD_EN && (ADDR == 8'h00 || ADDR == 8'h0C) |=> RD_DATA[29:9] == 21'h0)
		else $error("control unused bits not zero");
	chk_unmapped_zero: assert property (RD_EN && ADDR > 8'h20 |=> RD_DATA == 32'h0)
		else $error("unmapped read not zero");
	chk_irq_cause: assert property (IRQ |-> CAUSE_PERF_PENDING)
		else $error("interrupt without pending flag");
	chk_irq_mask: assert property (WR_EN && ADDR == 8'h1C && WR_DATA[1:0] == 2'h0 |=> !IRQ)
		else $error("interrupt survives mask write");
	chk_pending_sticky: assert property (CAUSE_PERF_PENDING && !(WR_EN && ADDR == 8'h20) |=> CAUSE_PERF_PENDING)
		else $error("pending flag dropped without clear");
	chk_reset_quiet: assert property ($fell(SYS_RST) |-> !IRQ && !CAUSE_PERF_PENDING && RD_DATA == 32'h0)
		else $error("outputs not quiet after reset");
endmodule // pec_top_chk

bind pec_top pec_top_chk pec_top_chk_inst (.CLK, .SYS_RST, .ADDR, .WR_DATA, .WR_EN, .RD_EN, .RD_DATA, .IRQ,
	.CAUSE_PERF_PENDING);

/* File: pec_core_model.sv */
// core pipeline model raising the strobe behind one chosen event code
`timescale 1ns/1ps
module pec_core_model (
	input  wire        ctr,
	input  wire [3:0]  code,
	input  wire        fire,
	input  wire        half,
	input  wire        alt,
	output reg  [32:0] strobes,
	output reg  [5:0]  exc_code
);
	integer i;

	// half: request without accept, or exception with a code that must not count
	always @* begin
		strobes = 33'h0;
		exc_code = 6'h15;
		i = 40;
		case ({ctr, code})
		5'h00: i = 40;
		5'h04: strobes[29:28] = {fire | half, fire};
		5'h09: strobes[23:22] = {fire | half, fire};
		5'h0D: begin
			strobes[18] = fire | half;
			exc_code = half ? 6'h01 : (alt ? 6'h23 : 6'h22);
		end
		5'h0E: begin
			strobes[18] = fire | half;
			exc_code = half ? 6'h3F : 6'h00;
		end
		5'h0F: begin
			strobes[18] = fire | half;
			exc_code = half ? 6'h00 : 6'h3F;
		end
		5'h14: strobes[13:12] = {fire | half, fire};
		5'h17: strobes[9:8] = {fire | half, fire};
		5'h19: strobes[6:5] = {fire | half, fire};
		5'h1C: begin
			strobes[18] = fire | half;
			strobes[2] = fire;
		end
		5'h1D: strobes[18] = fire;
		// counter 1 codes 14 and 15 sit on bits 1 and 0, past the gap left by codes 12 and 13
		default: i = ctr ? (code < 4 ? 17 - code : code < 7 ? 16 - code : code == 8 ? 7
			: code < 12 ? 14 - code : 15 - code)
			: (code < 4 ? 33 - code : code < 9 ? 32 - code : 31 - code);
		endcase
		if (i < 33)
			strobes[i] = fire;
	end
endmodule // pec_core_model

/* File: tb_top.sv */
// self-checking bench for the performance event counter block
`timescale 1ns/1ps
`include "pec_defs.vh"
module tb_top;
	logic        CLK = 0, SYS_RST = 1, WR_EN = 0, RD_EN = 0, EXCEPTION_LEVEL_FLAG = 0, ERROR_LEVEL_FLAG = 1;
	logic [7:0]  ADDR = 8'h00;
	logic [31:0] WR_DATA = 32'h0;
	logic [1:0]  PRIVILEGE_MODE_FIELD = 2'h2;
	wire  [31:0] RD_DATA;
	wire         IRQ, CAUSE_PERF_PENDING;
	wire  [5:0]  exc_code;
	wire  [32:0] s;
	logic        p_ctr = 0, p_fire = 0, p_half = 0, p_alt = 0, rd_pend = 0, hit;
	logic [3:0]  p_code = 4'h0;
	logic [31:0] rng = 32'h47, r, n, exp_q[$];
	logic [7:0]  base;
	int          miscompares = 0, num_checks = 0, c;

	initial forever #10 CLK = ~CLK;

	pec_core_model pec_core_model_inst (.ctr(p_ctr), .code(p_code), .fire(p_fire), .half(p_half), .alt(p_alt),
		.strobes(s), .exc_code(exc_code));
	pec_top pec_top_inst (.CLK, .SYS_RST, .ADDR, .WR_DATA, .WR_EN, .RD_EN, .RD_DATA, .IRQ, .CAUSE_PERF_PENDING,
		.PRIVILEGE_MODE_FIELD, .EXCEPTION_LEVEL_FLAG, .ERROR_LEVEL_FLAG, .EXCEPTION_CODE(exc_code),
		.BRANCH_VALID(s[32]), .JUMP_REG_STROBE(s[31]), .RETURN_JUMP_STROBE(s[30]), .IMEM_RD_VALID(s[29]),
		.IMEM_RD_ALLOW(s[28]), .INT_UNIT_A_ISSUE(s[27]), .MEM_UNIT_ISSUE(s[26]), .FP_UNIT_A_ISSUE(s[25]),
		.BHT_PREDICT(s[24]), .MREAD_VALID(s[23]), .MREAD_ALLOW(s[22]), .FIX_QUEUE_FULL(s[21]),
		.REORDER_QUEUE_FULL(s[20]), .SYSCTL_QUEUE_FULL(s[19]), .EXCEPTION_STROBE(s[18]), .COMMIT_VALID(s[17]),
		.BRANCH_MISPREDICT(s[16]), .JUMP_REG_MISPREDICT(s[15]), .RETURN_JUMP_MISPREDICT(s[14]),
		.DMEM_RD_VALID(s[13]), .DMEM_RD_ALLOW(s[12]), .INT_UNIT_B_ISSUE(s[11]), .FP_UNIT_B_ISSUE(s[10]),
		.UNCACHED_VALID(s[9]), .UNCACHED_ALLOW(s[8]), .BHT_MISPREDICT(s[7]), .MWRITE_VALID(s[6]),
		.MWRITE_ALLOW(s[5]), .FP_QUEUE_FULL(s[4]), .BRANCH_QUEUE_FULL(s[3]), .ITLB_PROBE_OP(s[2]),
		.LOAD_SPEC_MISS(s[1]), .SYSCTL_LOAD_FORWARD(s[0]));

	function automatic logic [31:0] xs();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		ADDR <= a;
		WR_DATA <= d;
		WR_EN <= 1'b1;
		RD_EN <= 1'b0;
		@(posedge CLK);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		ADDR <= a;
		RD_EN <= 1'b1;
		WR_EN <= 1'b0;
		exp_q.push_back(e);
		@(posedge CLK);
	endtask

	// erl high in the idle state keeps every qualifier from matching
	task automatic tick(input logic [1:0] m, input logic x, input logic e, input logic [2:0] ev);
		WR_EN <= 1'b0;
		RD_EN <= 1'b0;
		PRIVILEGE_MODE_FIELD <= m;
		EXCEPTION_LEVEL_FLAG <= x;
		ERROR_LEVEL_FLAG <= e;
		{p_alt, p_half, p_fire} <= ev;
		@(posedge CLK);
	endtask

	task automatic outs(input logic i, input logic p);
		@(negedge CLK);
		check("IRQ", {31'h0, IRQ}, {31'h0, i});
		check("CAUSE_PERF_PENDING", {31'h0, CAUSE_PERF_PENDING}, {31'h0, p});
		@(posedge CLK);
	endtask

	always @(negedge CLK) begin
		if (rd_pend)
			check("RD_DATA", RD_DATA, exp_q.pop_front());
		rd_pend = RD_EN;
	end

	initial begin
		repeat (20000) @(posedge CLK);
		miscompares++;
		print_verdict();
	end

	initial begin
		repeat (3) @(posedge CLK);
		SYS_RST <= 1'b0;
		@(posedge CLK);
		rd(`PEC_ADDR_CTRL0, `PEC_CTRL0_RST);
		rd(`PEC_ADDR_CTRL1, `PEC_CTRL1_RST);
		rd(`PEC_ADDR_CNT0_LO, 32'h0);
		rd(`PEC_ADDR_IRQ_STAT, 32'h0);
		rd(8'h24, 32'h0);
		wr(`PEC_ADDR_CTRL0, 32'hFFFFFFFF);
		wr(`PEC_ADDR_CTRL1, 32'h0);
		rd(`PEC_ADDR_CTRL0, 32'hC00001FF);
		rd(`PEC_ADDR_CTRL1, `PEC_CTRL1_RST);
		for (c = 0; c < 32; c++) begin
			base = c[4] ? `PEC_ADDR_CTRL1 : `PEC_ADDR_CTRL0;
			p_ctr <= c[4];
			p_code <= c[3:0];
			wr(c[4] ? `PEC_ADDR_CTRL0 : `PEC_ADDR_CTRL1, 32'h0);
			wr(base, {23'h0, c[3:0], 5'h02});
			wr(base + 8'h04, 32'h0);
			wr(base + 8'h08, 32'h0);
			n = 32'h0;
			repeat (8) begin
				r = xs();
				tick(2'h0, 1'b0, 1'b0, {r[2], r[1] & ~r[0], r[0]});
				n = n + ((c == 0) ? 32'h1 : {31'h0, r[0]});
			end
			tick(2'h2, 1'b0, 1'b1, 3'h0);
			rd(base + 8'h04, n);
			rd(base + 8'h08, 32'h0);
		end
		wr(`PEC_ADDR_CTRL1, 32'h0);
		repeat (12) begin
			r = xs();
			hit = !r[3] && (r[2] ? r[4 + `PEC_Q_EXL] : (r[1:0] == `PEC_MODE_KERNEL && r[4 + `PEC_Q_K])
				|| (r[1:0] == `PEC_MODE_SUPER && r[4 + `PEC_Q_S]) || (r[1:0] == `PEC_MODE_USER && r[4 + `PEC_Q_U]));
			wr(`PEC_ADDR_CTRL0, {28'h0, r[7:4]});
			wr(`PEC_ADDR_CNT0_LO, 32'h0);
			repeat (3) tick(r[1:0], r[2], r[3], 3'h0);
			tick(2'h2, 1'b0, 1'b1, 3'h0);
			rd(`PEC_ADDR_CNT0_LO, hit ? 32'h3 : 32'h0);
		end
		// both counters overflow in turn, with and without their interrupt enable
		for (c = 0; c < 4; c++) begin
			base = c[1] ? `PEC_ADDR_CTRL1 : `PEC_ADDR_CTRL0;
			p_ctr <= c[1];
			p_code <= 4'h0;
			wr(`PEC_ADDR_IRQ_EN, {30'h0, c[1], !c[1]});
			wr(base, c[0] ? 32'h02 : 32'h12);
			wr(base + 8'h08, 32'h7FFFFFFF);
			wr(base + 8'h04, 32'hFFFFFFFF);
			tick(2'h0, 1'b0, 1'b0, 3'h1);
			repeat (2) tick(2'h2, 1'b0, 1'b1, 3'h0);
			outs(!c[0], !c[0]);
			rd(base + 8'h08, 32'h80000000);
			rd(`PEC_ADDR_IRQ_STAT, {30'h0, c[1] & !c[0], !c[1] & !c[0]});
			rd(`PEC_ADDR_IRQ_EN, {30'h0, c[1], !c[1]});
			wr(`PEC_ADDR_IRQ_EN, 32'h0);
			tick(2'h2, 1'b0, 1'b1, 3'h0);
			outs(1'b0, !c[0]);
			wr(`PEC_ADDR_IRQ_CLR, 32'h3);
			tick(2'h2, 1'b0, 1'b1, 3'h0);
			outs(1'b0, 1'b0);
		end
		repeat (3) @(posedge CLK);
		print_verdict();
	end
endmodule // tb_top
